// ===== rtl/capsel_top.sv
// Selector for two configurable auxiliary pins of the FIFO bridge
`timescale 1ns/100ps

module capsel_top (
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] cfg_sel_a,
	input wire logic [3:0] cfg_sel_b,
	input wire logic cfg_dcp_hold_high,
	input wire logic usb_configured,
	input wire logic usb_suspend,
	input wire logic dcp_attached,
	input wire logic sof_pulse,
	input wire logic pin_mode_write_strobe_n,
	input wire logic pin_mode_read_strobe_n,
	input wire logic cfg_pin_a_in,
	output logic cfg_pin_a_out,
	output logic cfg_pin_a_oe_n,
	input wire logic cfg_pin_b_in,
	output logic cfg_pin_b_out,
	output logic cfg_pin_b_oe_n,
	output logic bus_power_present,
	output logic suspend_block
);
	import capsel_pkg::*;

	// ****************************************
	// Pin drive decode
	// ****************************************
	function automatic capsel_drive_s pin_drive(
		input capsel_func_e f,
		input capsel_state_s s,
		input logic pwr_on,
		input logic slp,
		input logic dcp,
		input logic wr_n,
		input logic rd_n
	);
		capsel_drive_s d;
		d = DRIVE_RESET;
		case (f)
			FN_TRISTATE, FN_BUS_POWER_SENSE, FN_KEEP_AWAKE_N: begin
				d = DRIVE_RESET;
			end
			FN_DRIVE_1: begin
				d = '{out: 1'b1, oe_n: 1'b0};
			end
			FN_DRIVE_0: begin
				d = '{out: 1'b0, oe_n: 1'b0};
			end
			FN_POWER_ON_N: begin
				// Never drives high; the board resistor gives the high level
				d = '{out: 1'b0, oe_n: !pwr_on};
			end
			FN_SLEEP_N: begin
				d = '{out: slp, oe_n: 1'b0};
			end
			FN_CLK_FAST: begin
				d = '{out: s.clk_lvl[0], oe_n: 1'b0};
			end
			FN_CLK_MID: begin
				d = '{out: s.clk_lvl[1], oe_n: 1'b0};
			end
			FN_CLK_SLOW: begin
				d = '{out: s.clk_lvl[2], oe_n: 1'b0};
			end
			FN_CHARGER: begin
				d = '{out: dcp, oe_n: 1'b0};
			end
			FN_CHARGER_N: begin
				d = '{out: 1'b0, oe_n: !dcp};
			end
			FN_WRITE_STROBE_N: begin
				d = '{out: wr_n, oe_n: 1'b0};
			end
			FN_READ_STROBE_N: begin
				d = '{out: rd_n, oe_n: 1'b0};
			end
			FN_FRAME_TOGGLE: begin
				d = '{out: s.sof_lvl, oe_n: 1'b0};
			end
			default: begin
				// Unused codes leave the pad released
				d = DRIVE_RESET;
			end
		endcase
		return d;
	endfunction

	// ****************************************
	// State
	// ****************************************
	localparam capsel_state_s ST_RESET = '{
		loaded: 1'b0,
		sel_a: SEL_A_RESET,
		sel_b: SEL_B_RESET,
		hold_dcp: 1'b0,
		sync_a: SYNC_RESET,
		sync_b: SYNC_RESET,
		acc: ACC_RESET,
		clk_lvl: CLK_LVL_RESET,
		sof_lvl: 1'b0,
		pin_a: DRIVE_RESET,
		pin_b: DRIVE_RESET,
		bus_power_present: 1'b0,
		suspend_block: 1'b0
	};

	capsel_state_s st;
	capsel_state_s next_st;

	always_comb begin
		logic [31:0] sum;
		logic pwr_on;
		logic slp;
		sum = '0;
		pwr_on = 1'b0;
		slp = 1'b0;
		next_st = st;
		// Load once after reset; later changes of the setting are ignored
		if (!st.loaded) begin
			next_st.loaded = 1'b1;
			next_st.sel_a = capsel_func_e'(cfg_sel_a);
			next_st.sel_b = capsel_func_e'(cfg_sel_b);
			next_st.hold_dcp = cfg_dcp_hold_high;
		end
		next_st.sync_a = {st.sync_a[0], cfg_pin_a_in};
		next_st.sync_b = {st.sync_b[0], cfg_pin_b_in};
		// Fractional divider: exact mean rate, edges jitter by one clk period
		for (int i = 0; i < CLKOUT_NUM; i++) begin
			if (!usb_suspend) begin
				sum = 32'(st.acc[i] + CLKOUT_STEP[i]);
				if (sum >= CLK_HZ) begin
					next_st.acc[i] = 32'(sum - CLK_HZ);
					next_st.clk_lvl[i] = !st.clk_lvl[i];
				end else begin
					next_st.acc[i] = sum;
				end
			end
		end
		if (sof_pulse) begin
			next_st.sof_lvl = !st.sof_lvl;
		end
		pwr_on = usb_configured && !usb_suspend;
		slp = !usb_suspend || (st.hold_dcp && dcp_attached);
		next_st.pin_a = pin_drive(st.sel_a, st, pwr_on, slp, dcp_attached,
			pin_mode_write_strobe_n, pin_mode_read_strobe_n);
		next_st.pin_b = pin_drive(st.sel_b, st, pwr_on, slp, dcp_attached,
			pin_mode_write_strobe_n, pin_mode_read_strobe_n);
		next_st.bus_power_present = (st.sel_a == FN_BUS_POWER_SENSE && st.sync_a[1]) ||
			(st.sel_b == FN_BUS_POWER_SENSE && st.sync_b[1]);
		next_st.suspend_block = (st.sel_a == FN_KEEP_AWAKE_N && !st.sync_a[1]) ||
			(st.sel_b == FN_KEEP_AWAKE_N && !st.sync_b[1]);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= ST_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign cfg_pin_a_out = st.pin_a.out;
	assign cfg_pin_a_oe_n = st.pin_a.oe_n;
	assign cfg_pin_b_out = st.pin_b.out;
	assign cfg_pin_b_oe_n = st.pin_b.oe_n;
	assign bus_power_present = st.bus_power_present;
	assign suspend_block = st.suspend_block;

	// ****************************************
	// Checks
	// ****************************************
	logic hold_prev;
	logic [3:0] hold_cnt;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hold_prev <= 1'b0;
			hold_cnt <= 4'h0;
		end else begin
			hold_prev <= st.pin_a.out;
			if (st.pin_a.out != hold_prev) begin
				hold_cnt <= 4'h0;
			end else if (hold_cnt != 4'hf) begin
				hold_cnt <= hold_cnt + 4'h1;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_load;
		$rose(st.loaded) |-> st.sel_a == capsel_func_e'($past(cfg_sel_a)) &&
			st.sel_b == capsel_func_e'($past(cfg_sel_b));
	endproperty
	a_load: assert property (p_load) else $error("selection not taken from setting");

	property p_fixed;
		st.loaded |=> $stable(st.sel_a) && $stable(st.sel_b);
	endproperty
	a_fixed: assert property (p_fixed) else $error("selection changed in operation");

	property p_defaults;
		!st.loaded |-> st.sel_a == FN_BUS_POWER_SENSE;
	endproperty
	a_defaults: assert property (p_defaults) else $error("pin a default wrong");

	property p_default_b;
		!st.loaded |-> st.sel_b == FN_KEEP_AWAKE_N;
	endproperty
	a_default_b: assert property (p_default_b) else $error("pin b default wrong");

	property p_static;
		st.sel_a == FN_DRIVE_1 |=> cfg_pin_a_out && !cfg_pin_a_oe_n;
	endproperty
	a_static: assert property (p_static) else $error("constant one not driven");

	property p_tristate;
		st.sel_a == FN_TRISTATE || st.sel_a == FN_BUS_POWER_SENSE |=> cfg_pin_a_oe_n;
	endproperty
	a_tristate: assert property (p_tristate) else $error("released pin driven");

	property p_power;
		st.sel_a == FN_POWER_ON_N |=> !cfg_pin_a_out && cfg_pin_a_oe_n == !$past(usb_configured && !usb_suspend);
	endproperty
	a_power: assert property (p_power) else $error("power enable wrong");

	property p_sleep;
		st.sel_b == FN_SLEEP_N |=> !cfg_pin_b_oe_n &&
			cfg_pin_b_out == $past(!usb_suspend || (st.hold_dcp && dcp_attached));
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep indicator wrong");

	property p_clk_stop;
		st.sel_a == FN_CLK_FAST && usb_suspend |-> ##2 $stable(cfg_pin_a_out);
	endproperty
	a_clk_stop: assert property (p_clk_stop) else $error("clock ran in suspend");

	property p_clk_run;
		(st.sel_a == FN_CLK_FAST && !usb_suspend) [*8] ##1 (st.sel_a == FN_CLK_FAST && !usb_suspend) [*2]
			|-> hold_cnt < CLKOUT_MAX_HOLD;
	endproperty
	a_clk_run: assert property (p_clk_run) else $error("fast clock too slow");

	property p_charger;
		st.sel_a == FN_CHARGER_N |=> !cfg_pin_a_out && cfg_pin_a_oe_n == !$past(dcp_attached);
	endproperty
	a_charger: assert property (p_charger) else $error("inverted charger wrong");

	property p_strobe;
		st.sel_b == FN_READ_STROBE_N |=> cfg_pin_b_out == $past(pin_mode_read_strobe_n);
	endproperty
	a_strobe: assert property (p_strobe) else $error("read strobe wrong");

	property p_frame;
		st.sel_a == FN_FRAME_TOGGLE && st.loaded && sof_pulse |-> ##2 $changed(cfg_pin_a_out);
	endproperty
	a_frame: assert property (p_frame) else $error("frame toggle missed");

	property p_awake;
		(st.sel_b == FN_KEEP_AWAKE_N && !cfg_pin_b_in) [*3] |=> suspend_block;
	endproperty
	a_awake: assert property (p_awake) else $error("suspend prevent lost");

	property p_charger_hi;
		st.sel_a == FN_CHARGER |=> !cfg_pin_a_oe_n && cfg_pin_a_out == $past(dcp_attached);
	endproperty
	a_charger_hi: assert property (p_charger_hi) else $error("charger detect wrong");

	property p_write;
		st.sel_a == FN_WRITE_STROBE_N |=> !cfg_pin_a_oe_n && cfg_pin_a_out == $past(pin_mode_write_strobe_n);
	endproperty
	a_write: assert property (p_write) else $error("write strobe wrong");

	property p_sense;
		(st.sel_a == FN_BUS_POWER_SENSE && cfg_pin_a_in) [*3] |=> bus_power_present;
	endproperty
	a_sense: assert property (p_sense) else $error("bus power not seen");

	c_clk: cover property ((st.sel_a == FN_CLK_FAST && !usb_suspend) [*8]);
	c_frame: cover property (st.sel_a == FN_FRAME_TOGGLE && sof_pulse);
	c_awake: cover property (suspend_block);
	c_power: cover property (st.sel_a == FN_POWER_ON_N && $fell(cfg_pin_a_oe_n));
endmodule

// ===== shared/capsel_pkg.sv
// Package: function codes, constants and state layout of the aux pin selector
package capsel_pkg;
	typedef enum logic [3:0] {
		FN_TRISTATE,
		FN_DRIVE_1,
		FN_DRIVE_0,
		FN_POWER_ON_N,
		FN_SLEEP_N,
		FN_CLK_FAST,
		FN_CLK_MID,
		FN_CLK_SLOW,
		FN_CHARGER,
		FN_CHARGER_N,
		FN_WRITE_STROBE_N,
		FN_READ_STROBE_N,
		FN_BUS_POWER_SENSE,
		FN_FRAME_TOGGLE,
		FN_KEEP_AWAKE_N
	} capsel_func_e;

	localparam capsel_func_e SEL_A_RESET = FN_BUS_POWER_SENSE;
	localparam capsel_func_e SEL_B_RESET = FN_KEEP_AWAKE_N;

	localparam int unsigned CLK_HZ = 250_000_000;
	localparam int unsigned CLKOUT_FAST_HZ = 24_000_000;
	localparam int unsigned CLKOUT_MID_HZ = 12_000_000;
	localparam int unsigned CLKOUT_SLOW_HZ = 6_000_000;
	localparam int CLKOUT_NUM = 3;
	localparam logic [2:0][31:0] CLKOUT_STEP = {32'(2 * CLKOUT_SLOW_HZ), 32'(2 * CLKOUT_MID_HZ),
		32'(2 * CLKOUT_FAST_HZ)};
	localparam int CLKOUT_MAX_HOLD = (CLK_HZ + 2 * CLKOUT_FAST_HZ - 1) / (2 * CLKOUT_FAST_HZ);
	localparam logic [2:0][31:0] ACC_RESET = '0;
	localparam logic [2:0] CLK_LVL_RESET = 3'h0;
	localparam logic [1:0] SYNC_RESET = 2'h3;

	typedef struct packed {
		logic out;
		logic oe_n;
	} capsel_drive_s;

	localparam capsel_drive_s DRIVE_RESET = '{out: 1'b0, oe_n: 1'b1};

	typedef struct packed {
		logic loaded;
		capsel_func_e sel_a;
		capsel_func_e sel_b;
		logic hold_dcp;
		logic [1:0] sync_a;
		logic [1:0] sync_b;
		logic [2:0][31:0] acc;
		logic [2:0] clk_lvl;
		logic sof_lvl;
		capsel_drive_s pin_a;
		capsel_drive_s pin_b;
		logic bus_power_present;
		logic suspend_block;
	} capsel_state_s;
endpackage

// ===== verif/capsel_board_model.sv
// Board-side model of one aux pad with pull-up and external driver
`timescale 1ns/100ps

module capsel_board_model (
	input wire logic pin_out,
	input wire logic pin_oe_n,
	input wire logic ext_val,
	output logic pad
);
	// ****************
	// Pad resolution
	// ****************
	// Released pad shows the board level, never a stale driven value
	always_comb begin
		pad = pin_oe_n ? ext_val : pin_out;
	end
endmodule

// ===== verif/tb_capsel_top.sv
// Self-checking bench for the aux pin selector
`timescale 1ns/100ps

module tb_capsel_top;
	import capsel_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] sel_a = 4'h0, sel_b = 4'h0;
	logic hold = 1'b0, cfg = 1'b0, susp = 1'b0, dcp = 1'b0, sof = 1'b0, wr_n = 1'b1, rd_n = 1'b1;
	logic ext_a = 1'b1, ext_b = 1'b1, lvl = 1'b0;
	logic out_a, oe_a, out_b, oe_b, pad_a, pad_b, bpp, sblk;
	int n_mismatch = 0;
	int compares = 0;

	always #2 clk = ~clk;

	capsel_top dut (.clk(clk), .rst(rst), .cfg_sel_a(sel_a), .cfg_sel_b(sel_b),
		.cfg_dcp_hold_high(hold), .usb_configured(cfg), .usb_suspend(susp), .dcp_attached(dcp),
		.sof_pulse(sof), .pin_mode_write_strobe_n(wr_n), .pin_mode_read_strobe_n(rd_n),
		.cfg_pin_a_in(pad_a), .cfg_pin_a_out(out_a), .cfg_pin_a_oe_n(oe_a),
		.cfg_pin_b_in(pad_b), .cfg_pin_b_out(out_b), .cfg_pin_b_oe_n(oe_b),
		.bus_power_present(bpp), .suspend_block(sblk));
	capsel_board_model brd_a (.pin_out(out_a), .pin_oe_n(oe_a), .ext_val(ext_a), .pad(pad_a));
	capsel_board_model brd_b (.pin_out(out_b), .pin_oe_n(oe_b), .ext_val(ext_b), .pad(pad_b));

	// ****************
	// Expectations
	// ****************
	// Returns {oe_n, pad}; clock codes on pin a are judged by edge counts instead, on pin b not at all
	function automatic logic [1:0] exp_pin(input logic [3:0] c, input logic e);
		case (c)
			4'h1: return 2'b01;
			4'h2: return 2'b00;
			4'h3: return (cfg && !susp) ? 2'b00 : {1'b1, e};
			4'h4: return {1'b0, !susp || (hold && dcp)};
			4'h8: return {1'b0, dcp};
			4'h9: return dcp ? 2'b00 : {1'b1, e};
			4'ha: return {1'b0, wr_n};
			4'hb: return {1'b0, rd_n};
			4'hd: return {1'b0, lvl};
			default: return {1'b1, e};
		endcase
	endfunction

	task automatic check(input logic [1:0] got, input logic [1:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
		end
	endtask

	task automatic stop_test();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ****************
	// One test per selection pair
	// ****************
	task automatic run(input logic [3:0] a, input logic [3:0] b);
		int n;
		int m;
		int r;
		int f;
		logic p;
		logic ck;
		logic [1:0] sx;
		n = 0;
		m = 0;
		r = 0;
		ck = a inside {[4'h5:4'h7]};
		rst = 1'b1;
		sel_a = a;
		sel_b = b;
		{hold, ext_a, ext_b} = 3'($urandom);
		{cfg, susp, dcp, sof} = 4'h0;
		repeat (2) @(posedge clk);
		#1;
		check({oe_a, oe_b}, 2'b11, "pads in reset");
		rst = 1'b0;
		repeat (3) @(posedge clk);
		#1;
		lvl = 1'b0;
		p = pad_a;
		for (int i = 0; i < 350; i++) begin
			{sel_a, sel_b} = 8'($urandom);
			// Suspend window in the middle so the clock must also come back
			if (ck)
				susp = i >= 250 && i < 280;
			else
				{cfg, susp, dcp} = 3'($urandom);
			{sof, wr_n, rd_n} = 3'($urandom);
			@(posedge clk);
			#1;
			if (!ck)
				check({oe_a, pad_a}, exp_pin(a, ext_a), "pin a");
			if (!(b inside {[4'h5:4'h7]}))
				check({oe_b, pad_b}, exp_pin(b, ext_b), "pin b");
			lvl ^= sof;
			if (pad_a && !p && i < 250)
				n++;
			if (pad_a != p && i > 253 && i <= 280)
				m++;
			if (pad_a != p && i > 281)
				r++;
			p = pad_a;
		end
		if (ck) begin
			f = 24 >> (a - 4'h5);
			check({1'b0, n >= f - 1 && n <= f + 1}, 2'b01, "clock edge count");
			check({1'b0, m == 0}, 2'b01, "clock frozen");
			check({1'b0, r > 0}, 2'b01, "clock resumed");
		end
		sx = {(a == 4'hc && ext_a) || (b == 4'hc && ext_b), (a == 4'he && !ext_a) || (b == 4'he && !ext_b)};
		check({bpp, sblk}, sx, "sensed inputs");
		$display("test sel %0d/%0d done", a, b);
	endtask

	initial begin
		void'($urandom(56699));
		@(posedge clk);
		#1;
		for (int c = 0; c < 16; c++)
			run(4'(c), 4'($urandom));
		run(4'hc, 4'he);
		run(4'he, 4'hc);
		repeat (8) run(4'($urandom), 4'($urandom));
		stop_test();
	end

	// Runs take about 9230 cycles; generous margin before giving up
	initial begin
		#200000;
		n_mismatch++;
		$display("wrong value at %0t: watchdog expired", $time);
		stop_test();
	end
endmodule
